//--- common/amp_cfg.svh
// Register offsets, field positions, reset values and timing counts
`ifndef AMP_CFG_SVH
`define AMP_CFG_SVH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_VOL 8'h04
`define REG_TXEN 8'h08
`define REG_TXSLOT0 8'h0C
`define REG_TXSLOT1 8'h10
`define REG_ALIGN 8'h14
`define REG_IRQ_LIVE 8'h18
`define REG_IRQ_LATCH 8'h1C
`define REG_IRQ_MASK 8'h20
`define REG_STATUS 8'h24
`define REG_SHDN_EN 8'h28

// Control register fields
`define CTRL_MUTE 0
`define CTRL_RATE_LSB 1
`define CTRL_LCF_LSB 4
`define CTRL_IRQ_POL 7
`define CTRL_HIZ 8
`define CTRL_MODE_LSB 9
`define CTRL_ALIGN_EN 11

// Slot register fields
`define SLOT_FIELD_W 8
`define FLEN_LSB 16
`define ACNT_LSB 8
`define N_ITEMS 6
`define N_WIDE_ITEMS 3

// Reset values
`define CTRL_RST 32'h0000_0101
`define VOL_RST 32'h0000_0000
`define TXEN_RST 32'h0000_0000
`define TXSLOT0_RST 32'h0000_0000
`define TXSLOT1_RST 32'h0040_0000
`define ALIGN_RST 32'h0000_0000
`define MASK_RST 32'hFFFF_FFFF
`define SHDN_RST 32'h0000_0000

// Timing
`define CLK_PERIOD_NS 5
`define RAMP_STEP_NS 1000
`define RAMP_STEP_CYC (`RAMP_STEP_NS / `CLK_PERIOD_NS)

`endif

//--- common/amp_pkg.sv
// Shared types of the amplifier control block
package amp_pkg;
  // Limiter alignment modes
  typedef enum logic [1:0] {
    ALIGN_MIN,
    ALIGN_MIN_NZ,
    ALIGN_MAX
  } align_mode_t;

  // Low cut filter corner selections
  typedef enum logic [2:0] {
    LCF_BYPASS,
    LCF_2HZ,
    LCF_50HZ,
    LCF_100HZ,
    LCF_200HZ,
    LCF_400HZ,
    LCF_800HZ
  } lcf_t;
endpackage

//--- src/vol_ramp.sv
// Digital volume ramp toward target or mute level
`timescale 1ns/1ps
`include "amp_cfg.svh"
module vol_ramp #(
  parameter int STEP_CYC = `RAMP_STEP_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic [7:0] target_i,
  input wire logic mute_i,
  input wire logic [2:0] rate_i,
  // Level
  output logic [7:0] level_o
);
  logic [23:0] cnt_ff;
  logic [23:0] period;
  logic [7:0] dest;
  logic step_en;

  // Step period doubles per rate code
  assign period = 24'(STEP_CYC) << rate_i;
  assign dest = mute_i ? 8'h00 : target_i;
  assign step_en = (cnt_ff >= period - 24'h000001);

  // Step divider
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || step_en) begin
      cnt_ff <= 24'h000000;
    end else begin
      cnt_ff <= cnt_ff + 24'h000001;
    end
  end

  // One code per step, or jump when rate code is zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      level_o <= 8'h00;
    end else if (rate_i == 3'h0) begin
      level_o <= dest; // RULE1
    end else if (step_en && level_o < dest) begin
      level_o <= level_o + 8'h01; // RULE1
    end else if (step_en && level_o > dest) begin
      level_o <= level_o - 8'h01; // RULE1
    end
  end
endmodule // vol_ramp

//--- src/gain_align.sv
// Combines limiter attenuation reports of an alignment group
`timescale 1ns/1ps
module gain_align #(
  parameter int NGRP = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Configuration
  input wire logic enable_i,
  input wire amp_pkg::align_mode_t mode_i,
  input wire logic [3:0] count_i,
  // Attenuation inputs
  input wire logic [7:0] own_i,
  input wire logic [NGRP*8-1:0] grp_i,
  // Applied attenuation
  output logic [7:0] att_o
);
  logic [7:0] mn, mnz, mx, g, res;
  logic any_nz;

  // Minimum, minimum non-zero and maximum over group
  always_comb begin
    mn = 8'hFF;
    mnz = 8'hFF;
    mx = 8'h00;
    any_nz = 1'h0;
    g = 8'h00;
    for (int i = 0; i < NGRP; i++) begin
      if (4'(i) < count_i) begin
        g = grp_i[i*8 +: 8];
        if (g < mn) mn = g; // RULE8
        if (g > mx) mx = g; // RULE10
        if (g != 8'h00 && g < mnz) begin
          mnz = g; // RULE9
          any_nz = 1'h1;
        end
      end
    end
    if (!enable_i || count_i == 4'h0) begin
      res = own_i;
    end else begin
      case (mode_i)
        amp_pkg::ALIGN_MIN: res = mn; // RULE8
        amp_pkg::ALIGN_MIN_NZ: res = any_nz ? mnz : 8'h00; // RULE9
        amp_pkg::ALIGN_MAX: res = mx; // RULE10
        default: res = own_i;
      endcase
    end
  end

  // Registered result
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      att_o <= 8'h00;
    end else begin
      att_o <= res;
    end
  end
endmodule // gain_align

//--- src/amp_sense_limiter_control.sv
// Amplifier control: registers, sense output slots, alignment, interrupts
//
// Overview of operation
// RULE1: Volume ramps gradually at selectable rate
// RULE2: Sense and telemetry items placed on output
// RULE3: Voltage and current sent as 16-bit words
// RULE4: Output frame is 64 slots of 8 bits
// RULE5: Host keeps slot assignments from overlapping
// RULE6: Unused output bits drive zero or float
// RULE7: Aligned device sends and receives limiter gains
// RULE8: Minimum mode applies smallest group attenuation
// RULE9: Minimum non-zero mode ignores non-attenuating members
// RULE10: Maximum mode applies largest group attenuation
// RULE11: Members send gains in consecutive distinct slots
// RULE12: Start slot and count bound gain reading
// RULE13: Faults raise interrupts, some force shutdown
// RULE14: Live and latched flags both readable
// RULE15: Latched flag holds until read back
// RULE16: Interrupt pin level polarity configurable
// RULE17: Per-flag mask blocks interrupt pin
// RULE18: Low cut filter bypass or six corners
// RULE19: Latched flag sets whenever live condition
// RULE20: Items beyond frame length are not sent
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "amp_cfg.svh"
module amp_sense_limiter_control #(
  parameter int NFAULT = 8,
  parameter int NGRP = 8,
  parameter int RAMP_STEP_CYC = `RAMP_STEP_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // TDM link pins
  input wire logic tdm_bclk_i,
  input wire logic tdm_fsync_i,
  input wire logic serial_data_out_i,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_o,
  // Sense and telemetry inputs
  input wire logic [15:0] vsense_i,
  input wire logic [15:0] isense_i,
  input wire logic [15:0] pdm_dec_i,
  input wire logic [7:0] vbat_i,
  input wire logic [7:0] temp_i,
  input wire logic [7:0] own_att_i,
  // Fault conditions
  input wire logic [NFAULT-1:0] fault_i,
  // Control outputs
  output logic irq_o,
  output logic shutdown_o,
  output logic [7:0] volume_o,
  output logic [7:0] applied_att_o,
  output amp_pkg::lcf_t low_cut_filter_o
);
  localparam int IW = $clog2(NGRP);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Bit index inside slot run [s, s+n)
  function automatic logic in_range(input logic [9:0] b,
      input logic [5:0] s, input logic [6:0] n);
    logic [9:0] lo;
    logic [9:0] hi;
    lo = {1'h0, s, 3'h0};
    hi = lo + {n, 3'h0};
    in_range = (b >= lo) && (b < hi);
  endfunction

  // Byte-lane write merge
  function automatic logic [31:0] wmerge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (st[k]) r[k*8 +: 8] = d[k*8 +: 8];
    end
    wmerge = r;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_ff, vol_ff, txen_ff, tslot0_ff, tslot1_ff;
  logic [31:0] align_ff, mask_ff, shdn_ff;
  logic [NFAULT-1:0] latch_ff, flt1_ff, flt2_ff;
  logic [7:0] aw_addr_ff;
  logic aw_have_ff, w_have_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic do_wr, wr_ok, rd_go, rd_ok, rd_clr;
  logic [7:0] wa, ra;
  logic [31:0] rd_val;

  assign s_axi_awready_o = !aw_have_ff && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_have_ff && !s_axi_bvalid_o;
  assign do_wr = aw_have_ff && w_have_ff && !s_axi_bvalid_o;
  assign wa = {aw_addr_ff[7:2], 2'h0};
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign rd_go = s_axi_arvalid_i && s_axi_arready_o;
  assign ra = {s_axi_araddr_i[7:2], 2'h0};
  assign rd_clr = rd_go && (ra == `REG_IRQ_LATCH);

  // Address and data capture, either order
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_have_ff <= 1'h0;
      w_have_ff <= 1'h0;
      aw_addr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_have_ff <= 1'h1;
        aw_addr_ff <= s_axi_awaddr_i;
      end else if (do_wr) begin
        aw_have_ff <= 1'h0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_have_ff <= 1'h1;
        wdata_ff <= s_axi_wdata_i;
        wstrb_ff <= s_axi_wstrb_i;
      end else if (do_wr) begin
        w_have_ff <= 1'h0;
      end
    end
  end

  // Write decode
  always_comb begin
    case (wa)
      `REG_CTRL, `REG_VOL, `REG_TXEN, `REG_TXSLOT0, `REG_TXSLOT1,
      `REG_ALIGN, `REG_IRQ_MASK, `REG_SHDN_EN, `REG_IRQ_LIVE,
      `REG_IRQ_LATCH, `REG_STATUS: wr_ok = 1'h1;
      default: wr_ok = 1'h0;
    endcase
  end

  // Writable registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= `CTRL_RST;
      vol_ff <= `VOL_RST;
      txen_ff <= `TXEN_RST;
      tslot0_ff <= `TXSLOT0_RST;
      tslot1_ff <= `TXSLOT1_RST;
      align_ff <= `ALIGN_RST;
      mask_ff <= `MASK_RST;
      shdn_ff <= `SHDN_RST;
    end else if (do_wr) begin
      case (wa)
        `REG_CTRL: ctrl_ff <= wmerge(ctrl_ff, wdata_ff, wstrb_ff);
        `REG_VOL: vol_ff <= wmerge(vol_ff, wdata_ff, wstrb_ff);
        `REG_TXEN: txen_ff <= wmerge(txen_ff, wdata_ff, wstrb_ff);
        `REG_TXSLOT0: tslot0_ff <= wmerge(tslot0_ff, wdata_ff, wstrb_ff);
        `REG_TXSLOT1: tslot1_ff <= wmerge(tslot1_ff, wdata_ff, wstrb_ff);
        `REG_ALIGN: align_ff <= wmerge(align_ff, wdata_ff, wstrb_ff); // RULE12
        `REG_IRQ_MASK: mask_ff <= wmerge(mask_ff, wdata_ff, wstrb_ff);
        `REG_SHDN_EN: shdn_ff <= wmerge(shdn_ff, wdata_ff, wstrb_ff);
        default: ;
      endcase
    end
  end

  // Write response
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid_o <= 1'h0;
      s_axi_bresp_o <= 2'h0;
    end else if (do_wr) begin
      s_axi_bvalid_o <= 1'h1;
      s_axi_bresp_o <= wr_ok ? 2'h0 : 2'h2;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'h0;
    end
  end

  // Read mux
  always_comb begin
    rd_ok = 1'h1;
    case (ra)
      `REG_CTRL: rd_val = ctrl_ff;
      `REG_VOL: rd_val = vol_ff;
      `REG_TXEN: rd_val = txen_ff;
      `REG_TXSLOT0: rd_val = tslot0_ff;
      `REG_TXSLOT1: rd_val = tslot1_ff;
      `REG_ALIGN: rd_val = align_ff;
      `REG_IRQ_LIVE: rd_val = 32'(flt2_ff); // RULE14
      `REG_IRQ_LATCH: rd_val = 32'(latch_ff); // RULE14
      `REG_IRQ_MASK: rd_val = mask_ff;
      `REG_SHDN_EN: rd_val = shdn_ff;
      `REG_STATUS: rd_val = {15'h0000, shutdown_o, applied_att_o,
                             volume_o};
      default: begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'h0;
      end
    endcase
  end

  // Read response
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid_o <= 1'h0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= 2'h0;
    end else if (rd_go) begin
      s_axi_rvalid_o <= 1'h1;
      s_axi_rdata_o <= rd_val;
      s_axi_rresp_o <= rd_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts and shutdown
  // ----------------------------------------------------------------
  logic irq_act;

  // Fault synchroniser
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flt1_ff <= '0;
      flt2_ff <= '0;
    end else begin
      flt1_ff <= fault_i;
      flt2_ff <= flt1_ff; // RULE13
    end
  end

  // Latched flags: read clears, new condition wins
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      latch_ff <= '0;
    end else begin
      latch_ff <= (latch_ff & ~(rd_clr ? latch_ff : '0)) // RULE15
                  | flt2_ff; // RULE19
    end
  end

  assign irq_act = |(latch_ff & ~mask_ff[NFAULT-1:0]); // RULE17

  // Pin level and shutdown
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'h0;
      shutdown_o <= 1'h0;
    end else begin
      irq_o <= ctrl_ff[`CTRL_IRQ_POL] ? irq_act : !irq_act; // RULE16
      shutdown_o <= |(latch_ff & shdn_ff[NFAULT-1:0]); // RULE13
    end
  end

  // ----------------------------------------------------------------
  // TDM frame timing
  // ----------------------------------------------------------------
  logic [2:0] bclk_ff, fs_ff;
  logic [1:0] sdi_ff;
  logic bclk_rise, bclk_fall, fs_rise, fs_pend_ff, frame_go;
  logic [9:0] bit_ff, nxt_bit;
  logic [6:0] flen;
  logic [15:0] snap_ff [0:`N_ITEMS-1];

  // Pin synchronisers, third stage only for edges
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bclk_ff <= 3'h0;
      fs_ff <= 3'h0;
      sdi_ff <= 2'h0;
    end else begin
      bclk_ff <= {bclk_ff[1:0], tdm_bclk_i};
      fs_ff <= {fs_ff[1:0], tdm_fsync_i};
      sdi_ff <= {sdi_ff[0], serial_data_out_i};
    end
  end

  assign bclk_rise = bclk_ff[1] && !bclk_ff[2];
  assign bclk_fall = !bclk_ff[1] && bclk_ff[2];
  assign fs_rise = fs_ff[1] && !fs_ff[2];
  assign frame_go = bclk_rise && fs_pend_ff;
  assign flen = tslot1_ff[`FLEN_LSB +: 7]; // RULE4
  assign nxt_bit = frame_go ? 10'h000 :
                   (bit_ff == 10'h3FF) ? bit_ff : bit_ff + 10'h001;

  // Frame start pending and bit counter
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fs_pend_ff <= 1'h0;
      bit_ff <= 10'h3FF;
    end else begin
      if (fs_rise) fs_pend_ff <= 1'h1;
      else if (bclk_rise) fs_pend_ff <= 1'h0;
      if (bclk_rise) bit_ff <= nxt_bit;
    end
  end

  // Telemetry snapshot once per frame
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < `N_ITEMS; i++) snap_ff[i] <= 16'h0000;
    end else if (fs_rise) begin
      snap_ff[0] <= vsense_i; // RULE3
      snap_ff[1] <= isense_i; // RULE3
      snap_ff[2] <= pdm_dec_i; // RULE2
      snap_ff[3] <= {vbat_i, 8'h00}; // RULE2
      snap_ff[4] <= {temp_i, 8'h00}; // RULE2
      snap_ff[5] <= {own_att_i, 8'h00}; // RULE7
    end
  end

  // ----------------------------------------------------------------
  // Transmit
  // ----------------------------------------------------------------
  logic tx_hit, tx_bit;
  logic [5:0] slot;
  logic [6:0] nsl;
  logic [9:0] off;

  // Slot lookup for the next bit
  always_comb begin
    tx_hit = 1'h0;
    tx_bit = 1'h0;
    slot = 6'h00;
    nsl = 7'h00;
    off = 10'h000;
    for (int i = 0; i < `N_ITEMS; i++) begin
      slot = 6'({tslot1_ff, tslot0_ff} >> (i * `SLOT_FIELD_W));
      nsl = (i < `N_WIDE_ITEMS) ? 7'h02 : 7'h01; // RULE3
      if (txen_ff[i] && ({1'h0, slot} + nsl <= flen) // RULE20
          && in_range(nxt_bit, slot, nsl)) begin // RULE4
        tx_hit = 1'h1;
        off = nxt_bit - {1'h0, slot, 3'h0};
        tx_bit = snap_ff[i][4'hF - off[3:0]]; // RULE2
      end
    end
  end

  // Output pin driven after each bit clock rise
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      serial_data_out_o <= 1'h0;
      serial_data_out_oe_o <= 1'h0;
    end else if (bclk_rise) begin
      serial_data_out_o <= tx_hit && tx_bit; // RULE6
      serial_data_out_oe_o <= tx_hit || !ctrl_ff[`CTRL_HIZ]; // RULE6
    end
  end

  // ----------------------------------------------------------------
  // Receive group gains
  // ----------------------------------------------------------------
  logic [5:0] astart;
  logic [3:0] acnt;
  logic [6:0] sh_ff;
  logic [NGRP*8-1:0] grp_ff;
  logic rx_take;
  logic [6:0] rx_idx;

  assign astart = align_ff[5:0];
  assign acnt = align_ff[`ACNT_LSB +: 4];
  assign rx_take = bclk_fall && ctrl_ff[`CTRL_ALIGN_EN]
                   && in_range(bit_ff, 6'h00, flen)
                   && in_range(bit_ff, astart, {3'h0, acnt}); // RULE12
  assign rx_idx = bit_ff[9:3] - {1'h0, astart};

  // Gain bytes shifted in on the falling bit clock
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sh_ff <= 7'h00;
      grp_ff <= '0;
    end else if (rx_take) begin
      sh_ff <= {sh_ff[5:0], sdi_ff[1]};
      if (bit_ff[2:0] == 3'h7) begin
        grp_ff[rx_idx[IW-1:0]*8 +: 8] <= {sh_ff, sdi_ff[1]}; // RULE7
      end
    end
  end

  // ----------------------------------------------------------------
  // Submodules and plain outputs
  // ----------------------------------------------------------------
  gain_align #(.NGRP(NGRP)) u_align (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .enable_i(ctrl_ff[`CTRL_ALIGN_EN]),
    .mode_i(amp_pkg::align_mode_t'(ctrl_ff[`CTRL_MODE_LSB +: 2])),
    .count_i(acnt),
    .own_i(own_att_i),
    .grp_i(grp_ff),
    .att_o(applied_att_o)
  );

  vol_ramp #(.STEP_CYC(RAMP_STEP_CYC)) u_ramp (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .target_i(vol_ff[7:0]),
    .mute_i(ctrl_ff[`CTRL_MUTE] || shutdown_o), // RULE1
    .rate_i(ctrl_ff[`CTRL_RATE_LSB +: 3]),
    .level_o(volume_o)
  );

  // Filter corner select
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      low_cut_filter_o <= amp_pkg::LCF_BYPASS;
    end else if (ctrl_ff[`CTRL_LCF_LSB +: 3] > 3'h6) begin
      low_cut_filter_o <= amp_pkg::LCF_BYPASS; // RULE18
    end else begin
      low_cut_filter_o <= amp_pkg::lcf_t'(ctrl_ff[`CTRL_LCF_LSB +: 3]);
    end
  end
endmodule // amp_sense_limiter_control

//--- sim/amp_sense_limiter_control_asserts.sv
// Port checks of the amplifier control block
`timescale 1ns/1ps
module amp_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register bus
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Link and control outputs
  input wire logic tdm_bclk_i,
  input wire logic serial_data_out_o,
  input wire logic shutdown_o,
  input wire logic [7:0] volume_o,
  input wire amp_pkg::lcf_t low_cut_filter_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  rd_answer_a: assert property (
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer missing");
  rd_hold_a: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read answer dropped");
  wr_answer_a: assert property (
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |-> ##[1:3] s_axi_bvalid_o)
    else $error("write answer missing");
  wr_hold_a: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write answer dropped");
  rd_err_a: assert property (
    s_axi_rvalid_o && s_axi_rresp_o == 2'b10 |-> s_axi_rdata_o == 32'h0)
    else $error("refused read carries data");
  lcf_code_a: assert property (
    low_cut_filter_o != 3'h7)
    else $error("filter code out of range");
  shdn_vol_a: assert property (
    shutdown_o && $past(shutdown_o) |-> volume_o <= $past(volume_o))
    else $error("volume rises in shutdown");
  line_quiet_a: assert property (
    !tdm_bclk_i [*8] |=> $stable(serial_data_out_o))
    else $error("output bit moved without bit clock");
endmodule // amp_asserts

//--- sim/tdm_peer.sv
// Far side of the link: bit clock, frame sync, peer gain senders
`timescale 1ns/1ps
module tdm_peer (
  // Line from the block
  input wire logic d_i,
  input wire logic oe_i,
  // Link pins
  output logic bclk_o,
  output logic fsync_o,
  output logic line_o
);
  logic [7:0] gain [5];
  logic cap [120];
  logic ocap [120];
  logic pbit, pdrv, idle;
  int start = 10, cnt = -1, own = 2;
  // Shared line; undriven it shows a changing pattern
  assign line_o = oe_i ? d_i : (pdrv ? pbit : idle);
  initial begin
    {bclk_o, fsync_o, pdrv, pbit, idle} = 5'h00;
  end
  // One frame; clock stands still between frames
  task automatic frame(input int n);
    int k;
    fsync_o = 1'b1;
    #40;
    for (int b = 0; b < n; b++) begin
      bclk_o = 1'b1;
      idle = ~idle;
      k = b / 8 - start;
      pdrv = k >= 0 && k <= cnt && k != own;
      pbit = pdrv ? gain[k][7 - b % 8] : 1'b0;
      #40;
      bclk_o = 1'b0;
      fsync_o = 1'b0;
      cap[b] = line_o;
      ocap[b] = oe_i;
      #40;
    end
    pdrv = 1'b0;
  endtask
endmodule // tdm_peer

//--- sim/tb.sv
// Self-checking bench of the amplifier control block
`timescale 1ns/1ps
`include "amp_cfg.svh"
module tb;
  // ----------
  // Signals
  // ----------
  logic clk_i, rst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
  logic s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, irq_o, shutdown_o;
  logic tdm_bclk_i, tdm_fsync_i, serial_data_out_i, serial_data_out_o;
  logic serial_data_out_oe_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, bs_q, rs_q;
  logic [3:0] s_axi_wstrb_i;
  logic [4:0] hv;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i, vbat_i, temp_i, own_att_i;
  logic [7:0] fault_i, volume_o, applied_att_o;
  logic [15:0] vsense_i, isense_i, pdm_dec_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd_q;
  amp_pkg::lcf_t low_cut_filter_o;
  logic e [120];
  int err_count, cmp_count, seed, n, t, mn, mx, nz;
  assign hv = {s_axi_rvalid_o, s_axi_arready_o, s_axi_bvalid_o,
    s_axi_wready_o, s_axi_awready_o};
  // Design and far side
  amp_sense_limiter_control #(.RAMP_STEP_CYC(2))
    u_amp_sense_limiter_control (.*);
  tdm_peer u_tdm_peer (.d_i(serial_data_out_o),
    .oe_i(serial_data_out_oe_o), .bclk_o(tdm_bclk_i),
    .fsync_o(tdm_fsync_i), .line_o(serial_data_out_i));
  // Clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #300000;
    err_count++;
    finish_test();
  end
  // ----------
  // Tasks
  // ----------
  task automatic chk(input logic [63:0] g, input logic [63:0] x);
    cmp_count++;
    if (g !== x) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  // Wait for one handshake bit, keep the answer seen with it
  task automatic hs(input int w);
    logic v;
    do begin
      @(negedge clk_i);
      v = hv[w];
      {rd_q, rs_q, bs_q} = {s_axi_rdata_o, s_axi_rresp_o, s_axi_bresp_o};
      @(posedge clk_i);
    end while (v !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    logic [4:0] h;
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    {s_axi_awvalid_i, s_axi_wvalid_i} <= 2'b11;
    {pa, pw} = 2'b11;
    while (pa || pw) begin
      @(negedge clk_i);
      h = hv;
      @(posedge clk_i);
      if (pa && h[0]) begin
        s_axi_awvalid_i <= 1'b0;
        pa = 1'b0;
      end
      if (pw && h[1]) begin
        s_axi_wvalid_i <= 1'b0;
        pw = 1'b0;
      end
    end
    s_axi_bready_i <= 1'b1;
    hs(2);
    s_axi_bready_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    hs(3);
    s_axi_arvalid_i <= 1'b0;
    s_axi_rready_i <= 1'b1;
    hs(4);
    s_axi_rready_i <= 1'b0;
  endtask
  // Expected line image of an item sent MSB first, whole or not at all
  task automatic put(input int s, input int w, input logic [15:0] v);
    if (s * 8 + w <= 112)
      for (int i = 0; i < w; i++) e[s * 8 + i] = v[w - 1 - i];
  endtask
  task automatic frame(input logic hz);
    logic o;
    @(posedge clk_i);
    #1.3;
    u_tdm_peer.frame(120);
    for (int b = 0; b < 120; b++) begin
      o = hz ? b / 8 == 12 : 1'b1;
      chk({u_tdm_peer.ocap[b], u_tdm_peer.ocap[b] & u_tdm_peer.cap[b]},
        {o, e[b]});
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------
  // Tests
  // ----------
  initial begin
    seed = 81;
    {rst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 4'h0;
    {s_axi_arvalid_i, s_axi_rready_i, fault_i} = 10'h000;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 48'h0;
    s_axi_wstrb_i = 4'hF;
    {vsense_i, isense_i} = $random(seed);
    {pdm_dec_i, vbat_i, temp_i} = $random(seed);
    own_att_i = 8'($random(seed)) | 8'h01;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(`REG_CTRL);
    chk(rd_q, `CTRL_RST);
    rd(`REG_IRQ_MASK);
    chk(rd_q, `MASK_RST);
    rd(8'h3C);
    chk({rd_q, rs_q}, {32'h0, 2'b10});
    wr(8'h3C, 32'h1);
    chk(bs_q, 2'b10);
    $display("test registers done");
    for (int c = 0; c < 8; c++) begin
      wr(`REG_CTRL, 32'h101 | (c << 4));
      cyc(2);
      chk(low_cut_filter_o, c == 7 ? 0 : c);
    end
    $display("test filter done");
    t = 8 + ($random(seed) & 15);
    wr(`REG_VOL, t);
    wr(`REG_CTRL, 32'h102);
    n = 0;
    while (volume_o !== t[7:0] && n < 999) begin
      @(negedge clk_i);
      n++;
    end
    chk(n >= 4 * t - 8 && n <= 4 * t + 4, 1);
    $display("test ramp done");
    wr(`REG_CTRL, 32'h2);
    wr(`REG_TXEN, 32'h3F);
    wr(`REG_TXSLOT0, 32'h070D_0401);
    wr(`REG_TXSLOT1, 32'h000E_0C00);
    e = '{default: 1'b0};
    put(0, 8, {8'h00, temp_i});
    put(1, 16, vsense_i);
    put(4, 16, isense_i);
    put(13, 16, pdm_dec_i);
    put(7, 8, {8'h00, vbat_i});
    put(12, 8, {8'h00, own_att_i});
    frame(1'b0);
    $display("test sense slots done");
    wr(`REG_TXEN, 32'h20);
    wr(`REG_ALIGN, 32'h0000_040A);
    for (int k = 0; k < 5; k++) u_tdm_peer.gain[k] = 8'($random(seed));
    u_tdm_peer.gain[1] = 8'h00;
    u_tdm_peer.gain[2] = own_att_i;
    u_tdm_peer.gain[4] = 8'hFF;
    u_tdm_peer.cnt = 4;
    e = '{default: 1'b0};
    put(12, 8, {8'h00, own_att_i});
    {mn, mx, nz} = {32'd255, 32'd0, 32'd0};
    for (int k = 0; k < 4; k++) begin
      t = u_tdm_peer.gain[k];
      mn = t < mn ? t : mn;
      mx = t > mx ? t : mx;
      nz = t != 0 && (nz == 0 || t < nz) ? t : nz;
    end
    for (int m = 0; m < 4; m++) begin
      wr(`REG_CTRL, 32'h902 | (m << 9));
      frame(1'b1);
      cyc(20);
      t = m == 0 ? mn : m == 1 ? nz : m == 2 ? mx : own_att_i;
      chk(applied_att_o, t);
    end
    $display("test alignment done");
    wr(`REG_CTRL, 32'h82);
    wr(`REG_IRQ_MASK, 32'hFFFF_FFF7);
    wr(`REG_SHDN_EN, 32'h8);
    @(posedge clk_i);
    fault_i <= 8'h28;
    cyc(6);
    chk({irq_o, shutdown_o}, 2'b11);
    rd(`REG_IRQ_LIVE);
    chk(rd_q, 32'h28);
    fault_i <= 8'h00;
    cyc(6);
    rd(`REG_IRQ_LIVE);
    chk({rd_q, irq_o}, {32'h0, 1'b1});
    rd(`REG_IRQ_LATCH);
    chk(rd_q, 32'h28);
    cyc(3);
    chk({irq_o, shutdown_o}, 2'b00);
    @(posedge clk_i);
    fault_i <= 8'h20;
    cyc(6);
    chk(irq_o, 1'b0);
    wr(`REG_CTRL, 32'h2);
    fault_i <= 8'h00;
    cyc(3);
    chk(irq_o, 1'b1);
    rd(`REG_IRQ_LATCH);
    chk(rd_q, 32'h20);
    $display("test interrupts done");
    finish_test();
  end
endmodule // tb
bind amp_sense_limiter_control amp_asserts u_amp_asserts (.*);
